// *** src/fsg_pkg.sv ***
// package: address map, register offsets and carrier types of the special sector guard
package fsg_pkg;

   // ------------------------------------------------------------
   // array address map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [23:0] DATA_BASE = 24'h800000;       // data array low space
   localparam logic [23:0] DATA_LAST = 24'h80ffff;
   localparam logic [23:0] DATA_SECT_SIZE = 24'h004000;  // 16 KB sectors
   localparam int DATA_SECT_SHIFT = 14;
   localparam int DATA_SECTORS = 4;
   localparam logic [23:0] DTEST_BASE = 24'hc00000;      // data test sector
   localparam logic [23:0] DTEST_LAST = 24'hc03fff;
   localparam logic [23:0] CTEST_BASE = 24'h400000;      // code test sector
   localparam logic [23:0] CTEST_LAST = 24'h403fff;
   localparam logic [23:0] SHADOW_BASE = 24'h200000;     // code shadow sector
   localparam logic [23:0] SHADOW_LAST = 24'h203fff;
   localparam logic [13:0] TEST_OTP_LAST = 14'h1fff;     // first 8 KB user area
   localparam logic [13:0] TEST_OTP2_FIRST = 14'h3d00;
   localparam logic [13:0] TEST_OTP2_LAST = 14'h3de7;
   localparam logic [13:0] TEST_OTP3_FIRST = 14'h3e00;
   localparam logic [13:0] TEST_OTP3_LAST = 14'h3eff;
   localparam logic [13:0] TEST_PRI_LOCK = 14'h3de8;
   localparam logic [13:0] TEST_SEC_LOCK = 14'h3df8;
   localparam logic [13:0] SHADOW_USER_LAST = 14'h3dcf;
   localparam logic [23:0] STORE_SIZE_KB = 24'h000040;   // 64 KB user store
   localparam logic [23:0] TEST_SIZE_KB = 24'h000010;    // 16 KB test sector

   // ------------------------------------------------------------
   // nonvolatile word images (byte address of 64-bit word)
   // ------------------------------------------------------------
   localparam logic [23:0] CENSOR_PASSWORD_IMAGE = 24'h203dd8;
   localparam logic [23:0] CENSOR_CONTROL_IMAGE = 24'h203de0;
   localparam logic [23:0] FLASH_ACCESS_PROTECT_IMAGE = 24'h203e00;
   localparam logic [23:0] USER_OPTIONS_IMAGE = 24'h203e18;
   localparam logic [23:0] UNIQUE_ID_LOW = 24'h403c10;
   localparam logic [23:0] UNIQUE_ID_HIGH = 24'h403c18;
   localparam logic [23:0] CODE_PRIMARY_LOCK_IMAGE = 24'h403de8;
   localparam logic [23:0] CODE_SECONDARY_LOCK_IMAGE = 24'h403df8;
   localparam logic [23:0] DATA_PRIMARY_LOCK_IMAGE = 24'hc03de8;
   localparam logic [23:0] DATA_SECONDARY_LOCK_IMAGE = 24'hc03df8;

   // ------------------------------------------------------------
   // wishbone register map (byte offsets, word aligned)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_MODULE_CONFIG = 8'h00;   // bit0 data, bit1 code protected_area_select
   localparam logic [7:0] REG_PRIMARY_LOCK = 8'h04;    // primary_block_lock_reg
   localparam logic [7:0] REG_SECONDARY_LOCK = 8'h08;  // secondary_block_lock_reg
   localparam logic [7:0] REG_STATUS = 8'h0c;          // busy, last verdict
   localparam logic [7:0] REG_OP_ADDR = 8'h10;         // request address
   localparam logic [7:0] REG_OP_CMD = 8'h14;          // write starts request
   localparam logic [7:0] REG_REJECT_COUNT = 8'h18;    // refused requests
   localparam int LOCK_LOW_POS = 0;        // low_space_lock_0..3 at bits 3:0
   localparam int LOCK_TEST_SHADOW_POS = 4;  // test_shadow_lock / secondary
   localparam int CMD_ERASE_POS = 0;       // 1 erase, 0 program
   localparam int CMD_USER_POS = 1;        // 1 user mode request
   localparam int CMD_CODE_POS = 2;        // 1 code array, 0 data array
   localparam logic [31:0] MODULE_CONFIG_RST = 32'h00000000;
   localparam logic [31:0] LOCK_RST = 32'h0000001f;  // all locked out of reset

   // ------------------------------------------------------------
   // timing: bank busy time per operation
   // ------------------------------------------------------------
   localparam int OP_TIME_NS = 40;
   localparam int CLK_PERIOD_NS = 4;
   localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FSG_OK, FSG_BAD_ADDR, FSG_LOCKED, FSG_NOT_ENABLED, FSG_NOT_USER, FSG_NO_ERASE
   } fsg_verdict_t;

   typedef struct packed {
      logic [23:0] addr;
      logic erase;
      logic user;
      logic code;
   } fsg_req_t;

   typedef struct packed {
      logic allow;
      fsg_verdict_t verdict;
      logic lockedSector;
   } fsg_res_t;

endpackage : fsg_pkg

// *** src/fsg_decode.sv ***
// module: combinational decode and permission check of one request
`timescale 1ns/1ps
module fsg_decode import fsg_pkg::*; #(
   parameter int SECTORS = DATA_SECTORS
) (
   input wire fsg_req_t req,
   input wire logic areaSelCode,
   input wire logic areaSelData,
   input wire logic [SECTORS-1:0] lowLockPri,
   input wire logic [SECTORS-1:0] lowLockSec,
   input wire logic tsLockPri,
   input wire logic tsLockSec,
   output fsg_res_t res
);
   logic [13:0] off;            // offset within a 16 KB sector
   logic inData, inTest, inShadow;
   logic [1:0] sect;

   assign off = req.addr[13:0];
   assign sect = req.addr[DATA_SECT_SHIFT +: 2];

   // ------------------------------------------------------------
   // verdict: priority is address, erase ban, enable, lock, user area
   // ------------------------------------------------------------
   always_comb begin
      inData = !req.code && req.addr >= DATA_BASE && req.addr <= DATA_LAST;
      inTest = req.code ? (req.addr >= CTEST_BASE && req.addr <= CTEST_LAST)
                        : (req.addr >= DTEST_BASE && req.addr <= DTEST_LAST);
      // shadow decoded only for the code array
      inShadow = req.code && req.addr >= SHADOW_BASE && req.addr <= SHADOW_LAST;
      res.lockedSector = 1'b0;
      res.verdict = FSG_OK;
      if (inData) begin
         // either lock register locks the sector
         res.lockedSector = lowLockPri[sect] | lowLockSec[sect];
         if (res.lockedSector) begin
            res.verdict = FSG_LOCKED;
         end
      end else if (inTest) begin
         res.lockedSector = tsLockPri | tsLockSec;
         if (req.erase) begin
            res.verdict = FSG_NO_ERASE;
         end else if (req.user && !(req.code ? areaSelCode : areaSelData)) begin
            res.verdict = FSG_NOT_ENABLED;
         end else if (res.lockedSector) begin
            res.verdict = FSG_LOCKED;
         end else if (req.user && off > TEST_OTP_LAST) begin
            res.verdict = FSG_NOT_USER;
         end
      end else if (inShadow) begin
         res.lockedSector = tsLockPri | tsLockSec;
         if (req.user && !areaSelCode) begin
            res.verdict = FSG_NOT_ENABLED;
         end else if (res.lockedSector) begin
            res.verdict = FSG_LOCKED;
         end
      end else begin
         res.verdict = FSG_BAD_ADDR;
      end
      res.allow = (res.verdict == FSG_OK);
   end

endmodule : fsg_decode

// *** src/flash_special_sector_guard.sv ***
// module: special sector guard with wishbone registers and bank interlock
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module flash_special_sector_guard import fsg_pkg::*; #(
   parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdef0123456789abcdef, // arbitrary
   parameter int SECTORS = DATA_SECTORS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // controller side: array read path
   input wire logic rdReq,
   input wire logic [23:0] rdAddr,
   output logic rdGrant,
   output logic [127:0] rdData,
   output logic rdValid,
   input wire logic [127:0] arrayRdData,
   // controller side: operation start towards the high voltage sequencer
   output logic hvStart,
   output fsg_req_t hvReq,
   output logic [63:0] hvData,
   input wire logic hvDone
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum {ST_IDLE, ST_CHECK, ST_BUSY} fsg_state_t;

   typedef struct packed {
      fsg_state_t st;
      logic ack;
      logic [31:0] rdat;
      logic areaSelCode;       // code array protected_area_select
      logic areaSelData;       // data array protected_area_select
      logic [31:0] priLock;    // primary_block_lock_reg
      logic [31:0] secLock;    // secondary_block_lock_reg
      logic [23:0] opAddr;
      logic [63:0] opData;
      fsg_req_t req;
      fsg_verdict_t verdict;
      logic [15:0] rejects;
      logic [7:0] cnt;
      logic start;
      logic rvalid;
      logic [127:0] rdata;
   } fsg_regs_t;

   fsg_regs_t cur_ff, nxt_cur;
   fsg_res_t res;               // decode answer for the latched request
   logic wbReq;                 // new bus access this cycle
   logic busy;                  // request under check, or bank is in program or erase
   logic idHit;                 // read hits the unique identifier words

   // ------------------------------------------------------------
   // permission check
   // ------------------------------------------------------------
   fsg_decode #(.SECTORS(SECTORS)) u_decode (
      .req(cur_ff.req),
      .areaSelCode(cur_ff.areaSelCode),
      .areaSelData(cur_ff.areaSelData),
      .lowLockPri(cur_ff.priLock[LOCK_LOW_POS +: SECTORS]),
      .lowLockSec(cur_ff.secLock[LOCK_LOW_POS +: SECTORS]),
      .tsLockPri(cur_ff.priLock[LOCK_TEST_SHADOW_POS]),
      .tsLockSec(cur_ff.secLock[LOCK_TEST_SHADOW_POS]),
      .res(res)
   );

   assign wbReq = wb_cyc_i && wb_stb_i && !cur_ff.ack;
   assign busy = (cur_ff.st != ST_IDLE);
   assign idHit = (rdAddr[23:4] == UNIQUE_ID_LOW[23:4]);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.ack = wbReq;          // one wait state, ack for one cycle
      nxt_cur.start = 1'b0;
      nxt_cur.rvalid = 1'b0;
      // register writes: config and lock registers take byte lane 0 only, the address takes lanes 0 to 2
      if (wbReq && wb_we_i) begin
         case (wb_adr_i)
            REG_MODULE_CONFIG: begin
               if (wb_sel_i[0]) begin
                  nxt_cur.areaSelData = wb_dat_i[0];
                  nxt_cur.areaSelCode = wb_dat_i[1];
               end
            end
            REG_PRIMARY_LOCK: begin
               if (wb_sel_i[0]) nxt_cur.priLock[7:0] = wb_dat_i[7:0];
            end
            REG_SECONDARY_LOCK: begin
               if (wb_sel_i[0]) nxt_cur.secLock[7:0] = wb_dat_i[7:0];
            end
            REG_OP_ADDR: begin
               for (int i = 0; i < 3; i++) begin
                  if (wb_sel_i[i]) nxt_cur.opAddr[8*i +: 8] = wb_dat_i[8*i +: 8];
               end
            end
            REG_OP_CMD: begin
               // a request while busy is dropped: one bank, one operation
               if (!busy) begin
                  nxt_cur.req.addr = {cur_ff.opAddr[23:3], 3'b000};
                  nxt_cur.req.erase = wb_dat_i[CMD_ERASE_POS];
                  nxt_cur.req.user = wb_dat_i[CMD_USER_POS];
                  nxt_cur.req.code = wb_dat_i[CMD_CODE_POS];
                  nxt_cur.opData = {wb_dat_i[31:8], 40'h0};
                  nxt_cur.st = ST_CHECK;
               end
            end
            default: begin
               // unmapped write has no effect
            end
         endcase
      end
      // register reads, unmapped reads as zero
      if (wbReq && !wb_we_i) begin
         case (wb_adr_i)
            REG_MODULE_CONFIG: nxt_cur.rdat = {30'h0, cur_ff.areaSelCode, cur_ff.areaSelData};
            REG_PRIMARY_LOCK: nxt_cur.rdat = cur_ff.priLock;
            REG_SECONDARY_LOCK: nxt_cur.rdat = cur_ff.secLock;
            REG_STATUS: nxt_cur.rdat = {28'h0, cur_ff.verdict, busy};
            REG_OP_ADDR: nxt_cur.rdat = {8'h0, cur_ff.opAddr};
            REG_REJECT_COUNT: nxt_cur.rdat = {16'h0, cur_ff.rejects};
            default: nxt_cur.rdat = 32'h0;
         endcase
      end
      // operation sequence
      case (cur_ff.st)
         ST_IDLE: begin
            // array reads only while no program or erase is running
            if (rdReq) begin
               nxt_cur.rvalid = 1'b1;
               nxt_cur.rdata = idHit ? UNIQUE_ID : arrayRdData;
            end
         end
         ST_CHECK: begin
            nxt_cur.verdict = res.verdict;
            if (res.allow) begin
               nxt_cur.start = 1'b1;  // shadow erase is an ordinary sector erase
               nxt_cur.cnt = 8'(OP_CYCLES);
               nxt_cur.st = ST_BUSY;
            end else begin
               // refused: no high voltage, array unchanged
               nxt_cur.rejects = cur_ff.rejects + 16'h1;
               nxt_cur.st = ST_IDLE;
            end
         end
         ST_BUSY: begin
            if (cur_ff.cnt != 8'h0) begin
               nxt_cur.cnt = cur_ff.cnt - 8'h1;
            end else if (hvDone) begin
               nxt_cur.st = ST_IDLE;
            end
         end
         default: nxt_cur.st = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cur_ff <= '0;
         cur_ff.st <= ST_IDLE;
         cur_ff.priLock <= LOCK_RST;
         cur_ff.secLock <= LOCK_RST;
         cur_ff.areaSelCode <= MODULE_CONFIG_RST[1];
         cur_ff.areaSelData <= MODULE_CONFIG_RST[0];
         cur_ff.rdata <= '1;          // erased value
         cur_ff.verdict <= FSG_OK;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wb_ack_o = cur_ff.ack;
   assign wb_dat_o = cur_ff.rdat;
   assign rdGrant = !busy && rdReq;
   assign rdValid = cur_ff.rvalid;
   assign rdData = cur_ff.rdata;
   assign hvStart = cur_ff.start;
   assign hvReq = cur_ff.req;
   assign hvData = cur_ff.opData;

endmodule : flash_special_sector_guard

// *** verif/fsg_flash_model.sv ***
// partner model: sequencer completion and erased array page data
`timescale 1ns/1ps
module fsg_flash_model import fsg_pkg::*; #(
   parameter int DONE_DELAY = 25
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hvStart,
   output logic hvDone,
   output logic [127:0] arrayRdData
);
   int waitCnt_ff; // cycles left of the high voltage operation
   // untouched array: every bit erased, so a page reads all ones
   assign arrayRdData = {128{1'b1}};
   // slow answer: done drops at start and returns well after the minimum busy time
   always_ff @(posedge clk_sys) begin
      if (!rst_n) waitCnt_ff <= 0;
      else if (hvStart) waitCnt_ff <= DONE_DELAY;
      else if (waitCnt_ff != 0) waitCnt_ff <= waitCnt_ff - 1;
   end
   assign hvDone = (waitCnt_ff == 0);
endmodule : fsg_flash_model

// *** verif/fsg_guard_checker.sv ***
// checker: port relations of the special sector guard
`timescale 1ns/1ps
module fsg_guard_checker import fsg_pkg::*; #(
   parameter logic [127:0] UNIQUE_ID = 128'h0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rdReq,
   input wire logic [23:0] rdAddr,
   input wire logic rdGrant,
   input wire logic [127:0] rdData,
   input wire logic rdValid,
   input wire logic [127:0] arrayRdData,
   input wire logic hvStart,
   input wire fsg_req_t hvReq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic inTest; // started operation lands in either test sector
   assign inTest = (hvReq.addr >= CTEST_BASE && hvReq.addr <= CTEST_LAST)
      || (hvReq.addr >= DTEST_BASE && hvReq.addr <= DTEST_LAST);
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_read_valid: assert property (rdReq && rdGrant |=> rdValid)
      else $error("granted read gave no page");
   chk_stray_valid: assert property (rdValid |-> $past(rdReq && rdGrant))
      else $error("page valid without granted read");
   chk_busy_no_read: assert property (hvStart |=> !rdGrant [*8])
      else $error("read granted while bank busy");
   chk_uid_read: assert property (rdValid && $past(rdAddr[23:4]) == 20'h403c1
      |-> rdData == UNIQUE_ID)
      else $error("identifier page wrong");
   chk_array_read: assert property (rdValid && $past(rdAddr[23:4]) != 20'h403c1
      |-> rdData == $past(arrayRdData))
      else $error("array page not passed through");
   chk_test_no_erase: assert property (hvStart && inTest |-> !hvReq.erase)
      else $error("test sector erase started");
   chk_test_user_area: assert property (hvStart && inTest && hvReq.user
      |-> hvReq.addr[13:0] <= TEST_OTP_LAST)
      else $error("user program outside first 8 KB");
   chk_shadow_code: assert property (hvStart && hvReq.addr[23:14] == SHADOW_BASE[23:14]
      |-> hvReq.code)
      else $error("shadow operation on data array");
   cover property (hvStart && hvReq.erase);
   cover property (rdValid && rdData == UNIQUE_ID);
   cover property (wb_ack_o && !wb_we_i);
endmodule : fsg_guard_checker
bind flash_special_sector_guard fsg_guard_checker #(.UNIQUE_ID(UNIQUE_ID)) i_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rdReq(rdReq),
   .rdAddr(rdAddr), .rdGrant(rdGrant), .rdData(rdData), .rdValid(rdValid),
   .arrayRdData(arrayRdData), .hvStart(hvStart), .hvReq(hvReq));

// *** verif/flash_special_sector_guard_tb.sv ***
// testbench: register, operation and read sequences for the special sector guard
`timescale 1ns/1ps
module flash_special_sector_guard_tb import fsg_pkg::*;;
   localparam logic [127:0] TB_IDENT = 128'h5a5a0f0f3c3c6969a5a5f0f0c3c39696; // arbitrary
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDatW = 32'h0, wbDatR, rdBack;
   logic wbAck, rdGrant, rdValid, hvStart, hvDone, rdReq = 1'b0;
   logic [23:0] rdAddr = 24'h000000;
   logic [127:0] rdData, arrayRdData;
   fsg_req_t hvReq;
   logic [63:0] hvData;
   int nFail = 0, checks = 0, nStart = 0, nRej = 0, nBase = 0;
   flash_special_sector_guard #(.UNIQUE_ID(TB_IDENT)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
      .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .rdReq(rdReq), .rdAddr(rdAddr),
      .rdGrant(rdGrant), .rdData(rdData), .rdValid(rdValid), .arrayRdData(arrayRdData),
      .hvStart(hvStart), .hvReq(hvReq), .hvData(hvData), .hvDone(hvDone));
   fsg_flash_model i_model (.clk_sys(clk_sys), .rst_n(rst_n), .hvStart(hvStart),
      .hvDone(hvDone), .arrayRdData(arrayRdData));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // count started high voltage operations
   always @(posedge clk_sys) begin
      if (hvStart === 1'b1) nStart <= nStart + 1;
   end
   task automatic cmp(input string name, input logic [127:0] exp, input logic [127:0] got);
      checks++;
      if (got !== exp) begin
         nFail++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp
   // one classic cycle; entered and left just after a rising edge
   task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= dat;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1);
      rd = wbDatR;
      // the slave answers one cycle after taking the request
      cmp("ack latency", 128'h2, 128'(n));
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk_sys);
   endtask : wbXfer
   // page read from the controller side
   task automatic pageRead(input logic [23:0] adr, input logic [127:0] exp);
      rdReq <= 1'b1;
      rdAddr <= adr;
      @(posedge clk_sys);
      rdReq <= 1'b0;
      @(posedge clk_sys);
      cmp("page valid", 1, {127'h0, rdValid});
      cmp("page data", exp, rdData);
   endtask : pageRead
   // set config and locks, request one operation, check verdict and start
   task automatic runOp(input logic [1:0] cfg, input logic [4:0] pri, input logic [4:0] sec,
      input logic [23:0] adr, input logic [2:0] cmd, input fsg_verdict_t exp);
      logic [31:0] st;
      int s0;
      int n;
      wbXfer(1'b1, REG_MODULE_CONFIG, {30'h0, cfg}, st);
      wbXfer(1'b1, REG_PRIMARY_LOCK, {27'h0, pri}, st);
      wbXfer(1'b1, REG_SECONDARY_LOCK, {27'h0, sec}, st);
      wbXfer(1'b1, REG_OP_ADDR, {8'h0, adr}, st);
      s0 = nStart;
      wbXfer(1'b1, REG_OP_CMD, {29'h0, cmd}, st);
      wbXfer(1'b0, REG_STATUS, 32'h0, st);
      cmp("verdict", {125'h0, exp}, {125'h0, st[3:1]});
      n = 0;
      while (st[0] !== 1'b0 && n < 100) begin
         wbXfer(1'b0, REG_STATUS, 32'h0, st);
         n++;
      end
      cmp("busy clears", 128'h0, {127'h0, st[0]});
      cmp("starts", (exp == FSG_OK) ? 128'h1 : 128'h0, 128'(nStart - s0));
      cmp("op req", {101'h0, adr[23:3], 3'b000, cmd[0], cmd[1], cmd[2]}, {101'h0, hvReq});
      if (exp != FSG_OK) nRej++;
   endtask : runOp
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      nFail++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      wbXfer(1'b0, REG_PRIMARY_LOCK, 32'h0, rdBack);
      cmp("primary lock reset", {96'h0, LOCK_RST}, {96'h0, rdBack});
      wbXfer(1'b0, REG_SECONDARY_LOCK, 32'h0, rdBack);
      cmp("secondary lock reset", {96'h0, LOCK_RST}, {96'h0, rdBack});
      wbXfer(1'b0, REG_MODULE_CONFIG, 32'h0, rdBack);
      cmp("config reset", {96'h0, MODULE_CONFIG_RST}, {96'h0, rdBack});
      wbXfer(1'b1, 8'h1c, 32'hffffffff, rdBack);
      wbXfer(1'b0, 8'h1c, 32'h0, rdBack);
      cmp("unmapped", 128'h0, {96'h0, rdBack});
      runOp(2'h0, 5'h1f, 5'h1f, 24'h800000, 3'b010, FSG_LOCKED);
      runOp(2'h0, 5'h00, 5'h00, 24'h800000, 3'b010, FSG_OK);
      runOp(2'h0, 5'h00, 5'h08, 24'h80c000, 3'b011, FSG_LOCKED);
      runOp(2'h0, 5'h07, 5'h00, 24'h80c000, 3'b011, FSG_OK);
      runOp(2'h0, 5'h00, 5'h00, 24'h810000, 3'b010, FSG_BAD_ADDR);
      runOp(2'h3, 5'h00, 5'h00, 24'hc00000, 3'b011, FSG_NO_ERASE);
      runOp(2'h0, 5'h00, 5'h00, 24'hc00000, 3'b001, FSG_NO_ERASE);
      runOp(2'h2, 5'h00, 5'h00, 24'hc00000, 3'b010, FSG_NOT_ENABLED);
      runOp(2'h1, 5'h00, 5'h10, 24'hc00000, 3'b010, FSG_LOCKED);
      runOp(2'h1, 5'h10, 5'h00, 24'hc01ff8, 3'b010, FSG_LOCKED);
      runOp(2'h1, 5'h00, 5'h00, 24'hc01ff8, 3'b010, FSG_OK);
      runOp(2'h1, 5'h00, 5'h00, 24'hc02000, 3'b010, FSG_NOT_USER);
      runOp(2'h3, 5'h00, 5'h00, 24'h403de8, 3'b110, FSG_NOT_USER);
      runOp(2'h2, 5'h00, 5'h00, 24'h200000, 3'b111, FSG_OK);
      runOp(2'h1, 5'h00, 5'h00, 24'h200000, 3'b111, FSG_NOT_ENABLED);
      runOp(2'h2, 5'h00, 5'h10, 24'h203e00, 3'b110, FSG_LOCKED);
      runOp(2'h3, 5'h00, 5'h00, 24'h200000, 3'b010, FSG_BAD_ADDR);
      wbXfer(1'b0, REG_REJECT_COUNT, 32'h0, rdBack);
      cmp("refusals", 128'(nRej), {96'h0, rdBack});
      // bank interlock: array reads are held off and a second command is dropped while busy
      nBase = nStart;
      wbXfer(1'b1, REG_OP_CMD, 32'ha5c3e106, rdBack);
      rdReq <= 1'b1;
      rdAddr <= 24'h800000;
      wbXfer(1'b1, REG_OP_CMD, 32'h00000007, rdBack);
      cmp("grant while busy", 128'h0, {127'h0, rdGrant});
      cmp("page while busy", 128'h0, {127'h0, rdValid});
      rdReq <= 1'b0;
      repeat (60) @(posedge clk_sys);
      cmp("starts while busy", 128'h1, 128'(nStart - nBase));
      cmp("op data", {64'h0, 64'ha5c3e10000000000}, {64'h0, hvData});
      pageRead(24'h403c10, TB_IDENT);
      pageRead(24'h800000, {128{1'b1}});
      end_of_test();
   end
endmodule : flash_special_sector_guard_tb
